// ==== hw/sssl_top.sv ====
// safety relay, mode slider and status led control with an ahb-lite register file
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module sssl_top
   import sssl_pkg::*;
#(
   parameter int unsigned READY_FAST = READY_FAST_CYC,
   parameter int unsigned READY_SLOW = READY_SLOW_CYC,
   parameter int unsigned DEBOUNCE   = DEBOUNCE_CYC,
   parameter int unsigned FB_SETTLE  = FB_SETTLE_CYC,
   parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
)
(
   input  wire logic        i_mclk,
   input  wire logic        i_nrst,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   input  wire logic [2:0]  i_mode_switch_bank,
   input  wire logic [1:0]  i_relay_fb,
   input  wire logic        i_fault,
   input  wire logic        i_switch_cond,
   output logic [1:0]       o_relay_drv,
   output logic             o_led_err,
   output logic             o_led_pwr,
   output logic             o_selftest_msg,
   output logic [7:0]       o_ser_tx_data,
   output logic             o_ser_tx_valid,
   input  wire logic        i_ser_tx_ready,
   input  wire logic [7:0]  i_ser_rx_data,
   input  wire logic        i_ser_rx_valid
);

   // elaboration check on the counts; the 32-bit counters bound the longest wait
   if (READY_FAST == 0 || READY_SLOW < READY_FAST || DEBOUNCE == 0
       || FB_SETTLE == 0 || BLINK_HALF == 0)
      $error("sssl_top: bad timing parameter");

   logic [2:0]      slider_meta;
   logic [2:0]      slider_sync;
   logic [2:0]      slider;
   logic [31:0]     deb_cnt;
   logic [1:0]      fb_meta;
   logic [1:0]      fb_sync;
   logic [31:0]     boot_cnt;
   logic            ready;
   sssl_state_type  state;
   sssl_state_type  next_state;
   logic [31:0]     fb_cnt;
   logic            fb_bad;
   logic            err_feedback;
   logic            err_fault;
   logic            error;
   logic            trip_latched;
   logic            trip;
   logic [1:0]      ctrl;
   logic [31:0]     blink_cnt;
   logic            blink;
   logic            ph_valid;
   logic            ph_write;
   logic [7:0]      ph_addr;
   logic            wr_ctrl;
   logic            wr_ser;
   logic            rd_ser;
   logic            addr_ok;
   logic            clr_pulse;
   logic            rx_full;
   logic [7:0]      rx_data;
   sssl_status_type status;
   logic [31:0]     rd_mux;

   // two-flop synchronisers for slider and feedback pins
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
      begin
         slider_meta <= 3'h0;
         slider_sync <= 3'h0;
         fb_meta     <= 2'h0;
         fb_sync     <= 2'h0;
      end
      else
      begin
         slider_meta <= i_mode_switch_bank;
         slider_sync <= slider_meta;
         fb_meta     <= i_relay_fb;
         fb_sync     <= fb_meta;
      end
   end

   // debounce: accept a new slider pattern only after the synced pins differed from the held one for DEBOUNCE cycles in a row
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
      begin
         slider  <= 3'h0;
         deb_cnt <= 32'h0;
      end
      else if (slider_sync == slider)
         deb_cnt <= 32'h0;
      else if (deb_cnt >= DEBOUNCE - 1)
      begin
         slider  <= slider_sync;
         deb_cnt <= 32'h0;
      end
      else
         deb_cnt <= deb_cnt + 32'h1;
   end

   // start-up timer; slider[1] picks the short or the long self-test
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
      begin
         boot_cnt <= 32'h0;
         ready    <= 1'b0;
      end
      else if (!ready)
      begin
         boot_cnt <= boot_cnt + 32'h1;
         if (slider[1] && boot_cnt >= READY_FAST - 1)
            ready <= 1'b1;
         else if (boot_cnt >= READY_SLOW - 1)
            ready <= 1'b1;
      end
   end

   // operating state from the debounced sliders
   always_comb
   begin
      next_state = ST_SELFTEST;
      if (ready)
      begin
         if (slider[0] && slider[2])
            next_state = ST_NORMAL;
         else if (slider[0])
            next_state = ST_PROG;
         else
            next_state = ST_FACTORY;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
         state <= ST_SELFTEST;
      else
         state <= next_state;
   end

   // feedback supervision: the opener must read closed while the relay is open
   assign fb_bad = (fb_sync[0] == o_relay_drv[0]) || (fb_sync[1] == o_relay_drv[1]);

   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
         fb_cnt <= 32'h0;
      else if (!fb_bad)
         fb_cnt <= 32'h0;
      else if (fb_cnt < FB_SETTLE)
         fb_cnt <= fb_cnt + 32'h1;
   end

   // sticky errors; a new cause wins over a software clear
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
      begin
         err_feedback <= 1'b0;
         err_fault    <= 1'b0;
      end
      else
      begin
         if (fb_cnt >= FB_SETTLE)
            err_feedback <= 1'b1;
         else if (clr_pulse)
            err_feedback <= 1'b0;
         if (i_fault)
            err_fault <= 1'b1;
         else if (clr_pulse)
            err_fault <= 1'b0;
      end
   end

   assign error = err_feedback || err_fault || fb_cnt >= FB_SETTLE || i_fault;

   // optional lock of the switching condition, released by clear
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
         trip_latched <= 1'b0;
      else if (ctrl[CTRL_LATCH_BIT] && i_switch_cond)
         trip_latched <= 1'b1;
      else if (clr_pulse || !ctrl[CTRL_LATCH_BIT])
         trip_latched <= 1'b0;
   end

   assign trip = i_switch_cond || trip_latched || ctrl[CTRL_TRIP_BIT];

   // relay drive: both coils together, open is the safe default
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
         o_relay_drv <= 2'h0;
      else if (next_state == ST_NORMAL && !error && !trip)
         o_relay_drv <= 2'h3;
      else
         o_relay_drv <= 2'h0;
   end

   // slow flash timebase
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
      begin
         blink_cnt <= 32'h0;
         blink     <= 1'b0;
      end
      else if (blink_cnt >= BLINK_HALF - 1)
      begin
         blink_cnt <= 32'h0;
         blink     <= ~blink;
      end
      else
         blink_cnt <= blink_cnt + 32'h1;
   end

   // status leds and self-test message
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
      begin
         o_led_err      <= 1'b1;
         o_led_pwr      <= 1'b0;
         o_selftest_msg <= 1'b0;
      end
      else
      begin
         o_led_pwr      <= 1'b1;
         o_selftest_msg <= !ready && !slider[1];
         if (error || state == ST_SELFTEST)
            o_led_err <= 1'b1;
         else if (state == ST_NORMAL)
            o_led_err <= 1'b0;
         else
            o_led_err <= blink;
      end
   end

   // ahb-lite address phase capture; zero wait states, always okay
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
      begin
         ph_valid    <= 1'b0;
         ph_write    <= 1'b0;
         ph_addr     <= 8'h0;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
      else if (i_hready)
      begin
         ph_valid <= i_hsel && i_htrans[HTRANS_ACTIVE_BIT] && addr_ok;  // no alias above 0xff
         ph_write <= i_hwrite;
         ph_addr  <= i_haddr[7:0];
      end
   end

   assign addr_ok   = i_haddr[31:8] == 24'h0;
   assign wr_ctrl   = ph_valid && ph_write && ph_addr == REG_CTRL;
   assign wr_ser    = ph_valid && ph_write && ph_addr == REG_SERIAL;
   assign clr_pulse = wr_ctrl && i_hwdata[CTRL_CLEAR_BIT];
   assign rd_ser    = i_hready && i_hsel && i_htrans[HTRANS_ACTIVE_BIT] && !i_hwrite
                      && addr_ok && i_haddr[7:0] == REG_SERIAL;

   // control register
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
         ctrl <= CTRL_RESET;
      else if (wr_ctrl)
         ctrl <= {i_hwdata[CTRL_LATCH_BIT], i_hwdata[CTRL_TRIP_BIT]};
   end

   // serial channel to the usb bridge
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
      begin
         o_ser_tx_data  <= 8'h0;
         o_ser_tx_valid <= 1'b0;
      end
      else if (wr_ser && !o_ser_tx_valid)
      begin
         o_ser_tx_data  <= i_hwdata[7:0];
         o_ser_tx_valid <= 1'b1;
      end
      else if (i_ser_tx_ready)
         o_ser_tx_valid <= 1'b0;
   end

   // received byte holding; arrival wins over the clearing read
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
      begin
         rx_full <= 1'b0;
         rx_data <= 8'h0;
      end
      else if (i_ser_rx_valid)
      begin
         rx_full <= 1'b1;
         rx_data <= i_ser_rx_data;
      end
      else if (rd_ser)
         rx_full <= 1'b0;
   end

   // read mux, loaded at the end of the address phase
   always_comb
   begin
      status              = '0;
      status.relay_fb     = fb_sync;
      status.relay_closed = o_relay_drv[0];
      status.trip_latched = trip_latched;
      status.err_fault    = err_fault;
      status.err_feedback = err_feedback;
      status.ready        = ready;
      status.selftest_msg = o_selftest_msg;
      status.state        = state;
      status.sliders      = slider;
      rd_mux              = 32'h0;
      if (addr_ok)
      begin
         unique case (i_haddr[7:0])
            REG_CTRL:   rd_mux = {30'h0, ctrl};
            REG_STATUS: rd_mux = status;
            REG_SERIAL: rd_mux = {22'h0, o_ser_tx_valid, rx_full, rx_data};
            default:    rd_mux = 32'h0;
         endcase
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
         o_hrdata <= 32'h0;
      else if (i_hready && i_hsel && !i_hwrite)
         o_hrdata <= rd_mux;
   end

   // checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   sequence s_fb_stuck;
      fb_cnt >= FB_SETTLE;
   endsequence

   sequence s_write_ser;
      wr_ser && !o_ser_tx_valid;
   endsequence

   property p_closed_only_ok;
      o_relay_drv != 2'h0 |-> state == ST_NORMAL && !$past(error) && !$past(trip);
   endproperty
   a_closed_only_ok: assert property (p_closed_only_ok)
      else $error("relay closed outside fault-free normal operation");

   property p_open_on_error;
      (error || trip) |=> o_relay_drv == 2'h0;
   endproperty
   a_open_on_error: assert property (p_open_on_error)
      else $error("relay not opened after error or trip");

   property p_fb_error;
      s_fb_stuck |=> err_feedback;
   endproperty
   a_fb_error: assert property (p_fb_error)
      else $error("feedback mismatch did not set error");

   property p_led_normal_dark;
      state == ST_NORMAL && !error |=> o_led_err == 1'b0 || $past(state) != ST_NORMAL;
   endproperty
   a_led_normal_dark: assert property (p_led_normal_dark)
      else $error("error led lit in clean normal operation");

   property p_led_flash;
      (state == ST_PROG || state == ST_FACTORY) && !error |=> o_led_err == $past(blink);
   endproperty
   a_led_flash: assert property (p_led_flash)
      else $error("error led not flashing in programming or factory state");

   property p_led_steady;
      (error || state == ST_SELFTEST) |=> o_led_err;
   endproperty
   a_led_steady: assert property (p_led_steady)
      else $error("error led dark during self-test or error");

   property p_prog_mode;
      ready && slider[0] && !slider[2] |=> state == ST_PROG;
   endproperty
   a_prog_mode: assert property (p_prog_mode)
      else $error("programming mode not entered");

   property p_fast_ready;
      $rose(ready) |-> boot_cnt == READY_FAST || boot_cnt == READY_SLOW;
   endproperty
   a_fast_ready: assert property (p_fast_ready)
      else $error("ready at wrong start-up time");

   property p_debounce;
      slider != $past(slider) |-> $past(deb_cnt) == DEBOUNCE - 1;
   endproperty
   a_debounce: assert property (p_debounce)
      else $error("slider accepted before debounce time");

   property p_serial_tx;
      s_write_ser |=> o_ser_tx_valid && o_ser_tx_data == $past(i_hwdata[7:0]);
   endproperty
   a_serial_tx: assert property (p_serial_tx)
      else $error("serial byte not presented after write");

endmodule

// ==== hw/sssl_pkg.sv ====
// package: constants, types and register map of the safety state logic
package sssl_pkg;

   // clock and timing
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
   localparam int unsigned READY_FAST_MS = 2000;
   localparam int unsigned READY_SLOW_MS = 8000;
   localparam int unsigned DEBOUNCE_MS   = 20;
   localparam int unsigned FB_SETTLE_MS  = 20;
   localparam int unsigned BLINK_HALF_MS = 500;
   localparam int unsigned READY_FAST_CYC = READY_FAST_MS * CYC_PER_MS;
   localparam int unsigned READY_SLOW_CYC = READY_SLOW_MS * CYC_PER_MS;
   localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * CYC_PER_MS;
   localparam int unsigned FB_SETTLE_CYC  = FB_SETTLE_MS * CYC_PER_MS;
   localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;

   // register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_SERIAL = 8'h08;

   // control register fields and reset value
   localparam int unsigned CTRL_TRIP_BIT  = 0;
   localparam int unsigned CTRL_LATCH_BIT = 1;
   localparam int unsigned CTRL_CLEAR_BIT = 2;
   localparam logic [1:0]  CTRL_RESET     = 2'h0;

   // serial register fields
   localparam int unsigned SER_VALID_BIT = 8;
   localparam int unsigned SER_BUSY_BIT  = 9;

   // ahb transfer type bit that marks an active transfer
   localparam int unsigned HTRANS_ACTIVE_BIT = 1;

   // operating states
   typedef enum logic [1:0]
   {
      ST_SELFTEST = 2'b00,
      ST_NORMAL   = 2'b01,
      ST_PROG     = 2'b10,
      ST_FACTORY  = 2'b11
   } sssl_state_type;

   // status register layout
   typedef struct packed
   {
      logic [18:0]    rsvd;
      logic [1:0]     relay_fb;
      logic           relay_closed;
      logic           trip_latched;
      logic           err_fault;
      logic           err_feedback;
      logic           ready;
      logic           selftest_msg;
      sssl_state_type state;
      logic [2:0]     sliders;
   } sssl_status_type;

endpackage

// ==== testbench/sssl_relay_model.sv ====
// relay pair model: break contacts follow the coils, optionally late or welded
`timescale 1ns/1ps
module sssl_relay_model
(
   input  wire logic       i_mclk,
   input  wire logic [1:0] i_drv,
   input  wire logic       i_slow,
   input  wire logic       i_weld,
   output logic [1:0]      o_fb
);
   logic [1:0] dly [0:4];

   // opener reads the inverse of the coil; slow mode stays inside the settle time
   always_ff @(posedge i_mclk)
   begin
      dly[0] <= ~i_drv;
      for (int k = 1; k < 5; k++)
         dly[k] <= dly[k-1];
   end

   // a welded first relay never reports open, the fault the unit must catch
   // slow path: 5 model stages plus 2 sync flops stay one cycle under a settle of 8
   assign o_fb = (i_slow ? dly[4] : dly[0]) & {1'b1, ~i_weld};
endmodule

// ==== testbench/test_safety_state_and_status_logic.sv ====
// self-checking bench of the safety relay, slider and status led block
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      checked++; \
      if ((g) !== (e)) \
      begin \
         n_fail++; \
         $display("BAD %s exp %h got %h", nm, e, g); \
      end \
   end
module test_safety_state_and_status_logic
   import sssl_pkg::*;
;
   localparam int RF = 50;
   localparam int RS = 200;
   localparam int BH = 10;

   logic        i_mclk, i_nrst, i_hsel, i_hwrite, i_fault, i_switch_cond;
   logic        i_ser_tx_ready, i_ser_rx_valid, slow, weld;
   logic        o_hreadyout, o_hresp, o_led_err, o_led_pwr, o_selftest_msg, o_ser_tx_valid;
   logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
   logic [1:0]  i_htrans, o_relay_drv, fb;
   logic [2:0]  i_hsize, i_mode_switch_bank;
   logic [7:0]  i_ser_rx_data, o_ser_tx_data;
   int          n_fail, checked, cnt;

   sssl_top #(.READY_FAST(RF), .READY_SLOW(RS), .DEBOUNCE(4), .FB_SETTLE(8), .BLINK_HALF(BH))
   sssl_top_inst
   (
      .i_mclk, .i_nrst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
      .i_hready(o_hreadyout), .o_hreadyout, .o_hresp, .o_hrdata, .i_mode_switch_bank,
      .i_relay_fb(fb), .i_fault, .i_switch_cond, .o_relay_drv, .o_led_err, .o_led_pwr,
      .o_selftest_msg, .o_ser_tx_data, .o_ser_tx_valid, .i_ser_tx_ready, .i_ser_rx_data,
      .i_ser_rx_valid
   );

   sssl_relay_model sssl_relay_model_inst
   (
      .i_mclk, .i_drv(o_relay_drv), .i_slow(slow), .i_weld(weld), .o_fb(fb)
   );

   // 40 MHz clock
   initial
   begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end

   task report_and_stop;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task tick(input int n);
      repeat (n) @(posedge i_mclk);
   endtask

   // outputs are judged mid-cycle, well clear of the launching edge
   task look;
      @(negedge i_mclk);
   endtask

   task wait_hready;
      int n;
      n = 0;
      @(posedge i_mclk);
      while (o_hreadyout !== 1'b1)
      begin
         n++;
         if (n > 50)
         begin
            n_fail++;
            report_and_stop;
         end
         @(posedge i_mclk);
      end
   endtask

   // one single word transfer: address phase, then data phase
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      tick(1);
      i_hsel <= 1'b1;
      i_haddr <= {24'h0, a};
      i_htrans <= 2'b10;
      i_hwrite <= wr;
      wait_hready;
      i_hsel <= 1'b0;
      i_htrans <= 2'b00;
      i_hwdata <= wd;
      wait_hready;
      rd = o_hrdata;
   endtask

   task do_reset(input logic [2:0] sl);
      tick(1);
      i_nrst <= 1'b0;
      i_mode_switch_bank <= sl;
      tick(12);
      i_nrst <= 1'b1;
   endtask

   // power-up: relay held open and led lit until the ready time runs out
   task t_power(input logic [2:0] sl, input int t_rdy);
      do_reset(sl);
      look;
      `CHK("pwr_in_reset", 1'b0, o_led_pwr)
      tick(t_rdy - 10);
      look;
      `CHK("relay_early", 2'h0, o_relay_drv)
      `CHK("led_selftest", 1'b1, o_led_err)
      `CHK("msg", ~sl[1], o_selftest_msg)
      tick(20);
      look;
      `CHK("relay_ready", 2'h3, o_relay_drv)
      `CHK("led_normal", 1'b0, o_led_err)
      `CHK("pwr_on", 1'b1, o_led_pwr)
      `CHK("msg_off", 1'b0, o_selftest_msg)
      $display("power-up test done, ready %0d", t_rdy);
   endtask

   // fault opens at once, stays open until cleared; a late partner is no error
   task t_fault;
      tick(1);
      slow <= 1'b1;
      i_fault <= 1'b1;
      tick(1);
      look;
      `CHK("relay_fault", 2'h0, o_relay_drv)
      `CHK("led_fault", 1'b1, o_led_err)
      tick(1);
      i_fault <= 1'b0;
      tick(10);
      look;
      `CHK("relay_sticky", 2'h0, o_relay_drv)
      ahb(1'b0, REG_STATUS, 32'h0);
      `CHK("err_bits", 2'b10, rd[8:7])
      ahb(1'b1, REG_CTRL, 32'h4);
      tick(4);
      look;
      `CHK("relay_clear", 2'h3, o_relay_drv)
      `CHK("led_clear", 1'b0, o_led_err)
      ahb(1'b0, REG_CTRL, 32'h0);
      `CHK("ctrl_rd", 32'h0, rd)
      slow <= 1'b0;
      $display("fault test done");
   endtask

   // switching condition, plain and latched
   task t_switch;
      tick(1);
      i_switch_cond <= 1'b1;
      tick(1);
      i_switch_cond <= 1'b0;
      look;
      `CHK("relay_cond", 2'h0, o_relay_drv)
      tick(3);
      look;
      `CHK("relay_reclose", 2'h3, o_relay_drv)
      ahb(1'b1, REG_CTRL, 32'h2);
      tick(1);
      i_switch_cond <= 1'b1;
      tick(1);
      i_switch_cond <= 1'b0;
      tick(5);
      look;
      `CHK("relay_latched", 2'h0, o_relay_drv)
      ahb(1'b0, REG_STATUS, 32'h0);
      `CHK("trip_latched", 1'b1, rd[9])
      ahb(1'b1, REG_CTRL, 32'h6);
      tick(3);
      look;
      `CHK("relay_unlatch", 2'h3, o_relay_drv)
      ahb(1'b1, REG_CTRL, 32'h0);
      $display("switch test done");
   endtask

   // welded contact found while the relay is commanded open by a software trip
   task t_weld;
      tick(1);
      weld <= 1'b1;
      ahb(1'b1, REG_CTRL, 32'h1);
      tick(12);
      ahb(1'b0, REG_STATUS, 32'h0);
      `CHK("err_fb", 1'b1, rd[7])
      `CHK("fb_seen", 2'b10, rd[12:11])
      ahb(1'b1, REG_CTRL, 32'h0);
      tick(3);
      look;
      `CHK("relay_weld", 2'h0, o_relay_drv)
      `CHK("led_weld", 1'b1, o_led_err)
      tick(1);
      weld <= 1'b0;
      // let the mismatch counter drain first, a live cause wins over the clear
      tick(4);
      ahb(1'b1, REG_CTRL, 32'h4);
      tick(3);
      look;
      `CHK("relay_unweld", 2'h3, o_relay_drv)
      $display("feedback test done");
   endtask

   // programming and factory states blink, error overrides, normal is dark
   task t_modes;
      logic [2:0]     sl [3];
      sssl_state_type st [3];
      logic           prev;
      sl = '{3'b011, 3'b110, 3'b010};
      st = '{ST_PROG, ST_FACTORY, ST_FACTORY};
      for (int i = 0; i < 3; i++)
      begin
         tick(1);
         i_mode_switch_bank <= sl[i];
         tick(12);
         ahb(1'b0, REG_STATUS, 32'h0);
         `CHK("state", st[i], rd[4:3])
         `CHK("relay_mode", 2'h0, o_relay_drv)
         cnt = 0;
         look;
         prev = o_led_err;
         repeat (4 * BH)
         begin
            look;
            if (o_led_err !== prev)
               cnt++;
            prev = o_led_err;
         end
         `CHK("blinks", 4, cnt)
      end
      tick(1);
      i_fault <= 1'b1;
      // the led follows the fault one edge later
      tick(1);
      cnt = 0;
      repeat (3 * BH)
      begin
         look;
         if (o_led_err !== 1'b1)
            cnt++;
      end
      `CHK("led_err_steady", 0, cnt)
      tick(1);
      i_fault <= 1'b0;
      i_mode_switch_bank <= 3'b111;
      ahb(1'b1, REG_CTRL, 32'h4);
      tick(12);
      look;
      `CHK("relay_norm", 2'h3, o_relay_drv)
      `CHK("led_norm", 1'b0, o_led_err)
      // a glitch shorter than the debounce must not leave normal operation
      tick(1);
      i_mode_switch_bank <= 3'b011;
      tick(2);
      i_mode_switch_bank <= 3'b111;
      cnt = 0;
      repeat (15)
      begin
         look;
         if (o_relay_drv !== 2'h3)
            cnt++;
      end
      `CHK("glitch", 0, cnt)
      $display("mode test done");
   endtask

   // byte channel to the usb bridge, with a stalling bridge, and an unmapped word
   task t_serial;
      ahb(1'b1, REG_SERIAL, 32'ha5);
      tick(1);
      look;
      `CHK("tx_valid", 1'b1, o_ser_tx_valid)
      `CHK("tx_data", 8'ha5, o_ser_tx_data)
      ahb(1'b0, REG_SERIAL, 32'h0);
      `CHK("tx_busy", 1'b1, rd[9])
      tick(1);
      i_ser_tx_ready <= 1'b1;
      tick(1);
      i_ser_tx_ready <= 1'b0;
      look;
      `CHK("tx_done", 1'b0, o_ser_tx_valid)
      tick(1);
      i_ser_rx_data <= 8'h3c;
      i_ser_rx_valid <= 1'b1;
      tick(1);
      i_ser_rx_valid <= 1'b0;
      i_ser_rx_data <= 8'hc3;
      ahb(1'b0, REG_SERIAL, 32'h0);
      `CHK("rx_byte", 9'h13c, rd[8:0])
      ahb(1'b0, REG_SERIAL, 32'h0);
      `CHK("rx_empty", 1'b0, rd[8])
      ahb(1'b1, 8'h0c, 32'hffffffff);
      ahb(1'b0, 8'h0c, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      `CHK("hresp", 1'b0, o_hresp)
      $display("serial test done");
   endtask

   // hang guard
   initial
   begin
      #2_000_000;
      n_fail++;
      report_and_stop;
   end

   // main sequence
   initial
   begin
      n_fail = 0;
      checked = 0;
      i_nrst = 1'b0;
      i_hsel = 1'b0;
      i_haddr = 32'h0;
      i_htrans = 2'b00;
      i_hwrite = 1'b0;
      i_hsize = 3'h2;
      i_hwdata = 32'h0;
      i_mode_switch_bank = 3'b101;
      i_fault = 1'b0;
      i_switch_cond = 1'b0;
      i_ser_tx_ready = 1'b0;
      i_ser_rx_data = 8'h0;
      i_ser_rx_valid = 1'b0;
      slow = 1'b0;
      weld = 1'b0;
      t_power(3'b101, RS);
      t_power(3'b111, RF);
      t_fault;
      t_switch;
      t_weld;
      t_modes;
      t_serial;
      report_and_stop;
   end
endmodule
